/* File: common/pic_defs.svh */
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// ==========================================================================
// Register offsets on the peripheral bus (word offsets from the base).
`define PIC_OFF_PRIO0       5'h00
`define PIC_OFF_PRIO6       5'h06
`define PIC_OFF_VBASE       5'h07
`define PIC_OFF_FMATCH0     5'h08
`define PIC_OFF_FLOW0       5'h09
`define PIC_OFF_FHIGH0      5'h0a
`define PIC_OFF_FMATCH1     5'h0b
`define PIC_OFF_FLOW1       5'h0c
`define PIC_OFF_FHIGH1      5'h0d
`define PIC_OFF_PEND0       5'h0e
`define PIC_OFF_PEND3       5'h11
`define PIC_OFF_CTRL        5'h16

// ==========================================================================
// Field widths and positions.
`define PIC_VBASE_W         14
`define PIC_FMATCH_W        6
`define PIC_FHIGH_W         5
`define PIC_CTRL_INT_BIT    15
`define PIC_CTRL_LVL_LSB    13
`define PIC_CTRL_VEC_LSB    6
`define PIC_CTRL_DIS_BIT    5
`define PIC_CTRL_ONES       16'h001c

// ==========================================================================
// Reset values and fixed codes.
`define PIC_PRIO_RST        16'h0000
`define PIC_VBASE_RST       14'h0000
`define PIC_FMATCH_RST      6'h00
`define PIC_FLOW_RST        16'h0000
`define PIC_FHIGH_RST       5'h00
`define PIC_FIXED_LEVEL     2'h3
`define PIC_FAST_LEVEL      2'h2

`endif

/* File: common/pic_pkg.sv */
package pic_pkg;

    // ======================================================================
    // Register bus request from the peripheral bus.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } bus_req_t;

    // Register bus answer.
    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } bus_rsp_t;

    // Request and vector presented to the core.
    typedef struct packed {
        logic        req;
        logic [1:0]  level_code;
        logic        fast;
        logic        boot;
        logic [20:0] addr;
    } core_req_t;

    // Start-up sequence, Gray coded.
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_RUN  = 2'b01
    } boot_state_t;

endpackage

/* File: rtl/prioritised_interrupt_controller.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pic_defs.svh"

// Function
// R1: Sixty-four sources, each given one of four levels, some levels fixed.
// R2: The lowest sources have a fixed level the priority fields cannot change.
// R3: Inside one level the lowest numbered active source wins.
// R4: Raise a request to the core and supply its service address.
// R5: Normal vector address is vector base joined with the vector number.
// R6: A higher level request than the current one may nest.
// R7: Core masks levels with two status bits; the mask arrives as input.
// R8: Control register shows the current level code 00, 01, 10 or 11.
// R9: Two fast slots, each with match, low and high address registers.
// R10: Software sets level 2, match number and handler address for fast.
// R11: Fast only when the winner matches a slot and sits at level 2.
// R12: A fast request outputs the slot address, not base plus number.
// R13: Fast decision is registered with the vector, ready before the fetch.
// R14: The core starts fast handling unless the fetched word is a jump.
// R15: After reset the start address is driven toward the core.
// R16: Functional mode from reset, no configuration write needed.
// R17: In wait or stop, a pending request asks for a clock restart.
// R18: Wake only for sources enabled before the low-power entry.
// R19: Peripheral bus slave with registers at base plus offset.
// R20: Pending follows the source level; only unmasked pending sources compete.
module prioritised_interrupt_controller
    import pic_pkg::*;
#(
    parameter int          NUM_SRC    = 64,
    parameter int          NUM_FIXED  = 8,
    parameter logic [20:0] RESET_ADDR = 21'h000000
) (
    // Clock and reset.
    input  wire logic               i_sys_clk,
    input  wire logic               i_sys_rst,
    // Peripheral bus register port.
    input  wire bus_req_t           i_bus,
    output bus_rsp_t                o_bus,
    // Interrupt sources, active high levels.
    input  wire logic [NUM_SRC-1:0] i_irq_src,
    // Core mask bits, high bit first.
    input  wire logic [1:0]         i_core_mask,
    // Core request and vector.
    output core_req_t               o_core,
    // Low-power handshake with the system integration logic.
    input  wire logic               i_low_power,
    output logic                    o_wake_req
);

    // ======================================================================
    // Elaboration checks.
    // The register map holds exactly 64 pending bits and 56 priority fields.
    // The read mux and the field layout are hard-wired to that map, so a
    // different count would silently misplace fields instead of failing.
    if (NUM_SRC != 64) begin : g_bad_src
        $error("NUM_SRC must be 64");
    end
    if (NUM_FIXED != 8) begin : g_bad_fixed
        $error("NUM_FIXED must be 8");
    end

    // ======================================================================
    // Storage.
    // Software-visible registers first, then the registered outputs, then
    // the combinational arbitration results.
    logic [15:0]                 prio_ff [7];
    logic [`PIC_VBASE_W-1:0]     vbase_ff;
    logic [`PIC_FMATCH_W-1:0]    fmatch_ff [2];
    logic [15:0]                 flow_ff [2];
    logic [`PIC_FHIGH_W-1:0]     fhigh_ff [2];
    logic                        int_dis_ff;
    logic [NUM_SRC-1:0]          pending_ff;
    logic [NUM_SRC-1:0]          wake_en_ff;
    logic                        lp_d_ff;
    logic                        wake_ff;
    boot_state_t                 state_ff;
    core_req_t                   core_ff;
    bus_rsp_t                    rsp_ff;

    // Per-source level and enable, decoded from the priority fields.
    logic [1:0]                  src_lvl [NUM_SRC];
    logic [NUM_SRC-1:0]          src_en;
    logic [6:0]                  hit [4];
    logic                        win_found;
    logic [1:0]                  win_lvl;
    logic [5:0]                  win_idx;
    logic                        fast0;
    logic                        fast1;
    core_req_t                   nxt_core;
    logic                        wr_en;

    // ======================================================================
    // Helper functions.
    // Address match, shared by every write and the read mux.
    // Keeping one compare function means an offset cannot drift between the two.
    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] off);
        addr_is = (a == off);
    endfunction

    // Lowest set bit with a found flag; scanning down leaves the lowest.
    // A plain loop keeps the encoder readable; it flattens into a priority
    // chain, which is the longest path of this block.
    function automatic logic [6:0] first_set(input logic [63:0] v);
        logic [6:0] r;
        r = 7'h00;
        for (int k = 63; k >= 0; k--) begin
            if (v[k]) begin
                r = {1'b1, 6'(k)};
            end
        end
        first_set = r;
    endfunction

    // Current level code seen by the core: none, level 0, level 1, level 2 or 3.
    // Levels 2 and 3 share one code, so the core cannot tell them apart here.
    function automatic logic [1:0] level_code(input logic found, input logic [1:0] lvl);
        if (!found) begin
            level_code = 2'h0;
        end else if (lvl == 2'h0) begin
            level_code = 2'h1;
        end else if (lvl == 2'h1) begin
            level_code = 2'h2;
        end else begin
            level_code = 2'h3;
        end
    endfunction

    // A strobe with both read and write set still writes; the read then
    // returns the value from before the write.
    assign wr_en = i_bus.wr;

    // ======================================================================
    // Register writes.
    // Priority fields; code 00 disables a source, 01..11 give levels 0..2.
    // A new level takes part in arbitration from the edge after the write.
    // Level 3 cannot be given by software; it is kept for the fixed sources.
    always_ff @(posedge i_sys_clk) begin
        for (int r = 0; r < 7; r++) begin
            if (i_sys_rst) begin
                prio_ff[r] <= `PIC_PRIO_RST; // R16
            end else if (wr_en && addr_is(i_bus.addr, 5'(r))) begin
                prio_ff[r] <= i_bus.wdata; // R1 R19
            end
        end
    end

    // Vector base.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            vbase_ff <= `PIC_VBASE_RST;
        end else if (wr_en && addr_is(i_bus.addr, `PIC_OFF_VBASE)) begin
            vbase_ff <= i_bus.wdata[`PIC_VBASE_W-1:0]; // R19
        end
    end

    // Fast slots; slot 1 sits three words after slot 0.
    // Both match registers reset to source 0, which is fixed at level 3 and
    // so can never be taken as fast before software programs a slot.
    always_ff @(posedge i_sys_clk) begin
        for (int s = 0; s < 2; s++) begin
            if (i_sys_rst) begin
                fmatch_ff[s] <= `PIC_FMATCH_RST;
                flow_ff[s]   <= `PIC_FLOW_RST;
                fhigh_ff[s]  <= `PIC_FHIGH_RST;
            end else if (wr_en) begin
                if (addr_is(i_bus.addr, `PIC_OFF_FMATCH0 + 5'(3 * s))) begin
                    fmatch_ff[s] <= i_bus.wdata[`PIC_FMATCH_W-1:0]; // R9
                end
                if (addr_is(i_bus.addr, `PIC_OFF_FLOW0 + 5'(3 * s))) begin
                    flow_ff[s] <= i_bus.wdata; // R9
                end
                if (addr_is(i_bus.addr, `PIC_OFF_FHIGH0 + 5'(3 * s))) begin
                    fhigh_ff[s] <= i_bus.wdata[`PIC_FHIGH_W-1:0]; // R9
                end
            end
        end
    end

    // Control register: only the disable bit is writable.
    // The status fields are live views, so writes to them are dropped.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            int_dis_ff <= 1'b0; // R16
        end else if (wr_en && addr_is(i_bus.addr, `PIC_OFF_CTRL)) begin
            int_dis_ff <= i_bus.wdata[`PIC_CTRL_DIS_BIT];
        end
    end

    // ======================================================================
    // Register reads.
    // Every access is acknowledged one cycle later; unmapped words read zero.
    // Read data is zero outside the acknowledge, so several slaves may share
    // an OR-combined return path without extra gating.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.ack   <= i_bus.rd | i_bus.wr; // R19
            rsp_ff.rdata <= 16'h0000;
            if (i_bus.rd) begin
                if (i_bus.addr <= `PIC_OFF_PRIO6) begin
                    rsp_ff.rdata <= prio_ff[i_bus.addr[2:0]];
                end else if (addr_is(i_bus.addr, `PIC_OFF_VBASE)) begin
                    rsp_ff.rdata <= 16'(vbase_ff);
                end else if (addr_is(i_bus.addr, `PIC_OFF_FMATCH0)) begin
                    rsp_ff.rdata <= 16'(fmatch_ff[0]);
                end else if (addr_is(i_bus.addr, `PIC_OFF_FLOW0)) begin
                    rsp_ff.rdata <= flow_ff[0];
                end else if (addr_is(i_bus.addr, `PIC_OFF_FHIGH0)) begin
                    rsp_ff.rdata <= 16'(fhigh_ff[0]);
                end else if (addr_is(i_bus.addr, `PIC_OFF_FMATCH1)) begin
                    rsp_ff.rdata <= 16'(fmatch_ff[1]);
                end else if (addr_is(i_bus.addr, `PIC_OFF_FLOW1)) begin
                    rsp_ff.rdata <= flow_ff[1];
                end else if (addr_is(i_bus.addr, `PIC_OFF_FHIGH1)) begin
                    rsp_ff.rdata <= 16'(fhigh_ff[1]);
                end else if (i_bus.addr >= `PIC_OFF_PEND0 && i_bus.addr <= `PIC_OFF_PEND3) begin
                    rsp_ff.rdata <= pending_ff[16 * (i_bus.addr - `PIC_OFF_PEND0) +: 16];
                end else if (addr_is(i_bus.addr, `PIC_OFF_CTRL)) begin
                    rsp_ff.rdata <= `PIC_CTRL_ONES; // R8
                    rsp_ff.rdata[`PIC_CTRL_INT_BIT] <= core_ff.req;
                    rsp_ff.rdata[`PIC_CTRL_LVL_LSB +: 2] <= core_ff.level_code;
                    rsp_ff.rdata[`PIC_CTRL_VEC_LSB +: 7] <= {1'b0, win_idx};
                    rsp_ff.rdata[`PIC_CTRL_DIS_BIT] <= int_dis_ff;
                end
            end
        end
    end

    assign o_bus = rsp_ff;

    // ======================================================================
    // Source levels.
    // Fixed sources sit at the top level and ignore the priority fields.
    // Field code 00 disables a programmable source; codes 01 to 11 map to levels 0 to 2.
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        if (i < NUM_FIXED) begin : g_fixed
            assign src_en[i]  = 1'b1; // R2
            assign src_lvl[i] = `PIC_FIXED_LEVEL; // R2
        end else begin : g_prog
            localparam int R = (i - NUM_FIXED) / 8;
            localparam int F = ((i - NUM_FIXED) % 8) * 2;
            assign src_en[i]  = (prio_ff[R][F +: 2] != 2'h0); // R1
            assign src_lvl[i] = prio_ff[R][F +: 2] - 2'h1; // R1
        end
    end

    // Pending bits follow the sources while they stay asserted.
    // Nothing is latched: a source that drops before it is serviced is lost,
    // so every source must hold its line until software clears it.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pending_ff <= '0;
        end else begin
            pending_ff <= i_irq_src; // R20
        end
    end

    // ======================================================================
    // Arbitration.
    // One priority encoder per level, lowest source number first.
    // The four encoders run in parallel so the level choice adds only a small mux.
    for (genvar l = 0; l < 4; l++) begin : g_lvl
        logic [NUM_SRC-1:0] cand;
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_cand
            assign cand[i] = pending_ff[i] & src_en[i] & (src_lvl[i] == 2'(l)); // R20
        end
        assign hit[l] = first_set(cand); // R3
    end

    // Highest unmasked level wins; the core mask lets higher levels nest.
    // The mask is used as it arrives, and its effect reaches the core one
    // edge later through the registered request.
    always_comb begin
        win_found = 1'b0;
        win_lvl   = 2'h0;
        win_idx   = 6'h00;
        for (int l = 0; l < 4; l++) begin
            if (hit[l][6] && (l >= int'(i_core_mask))) begin // R6 R7 R20
                win_found = 1'b1;
                win_lvl   = 2'(l);
                win_idx   = hit[l][5:0]; // R3
            end
        end
    end

    // Fast match needs both a slot hit and level 2.
    // A match at any other level falls back to the normal base-plus-number vector.
    assign fast0 = win_found && (win_lvl == `PIC_FAST_LEVEL) && (win_idx == fmatch_ff[0]); // R11
    assign fast1 = win_found && (win_lvl == `PIC_FAST_LEVEL) && (win_idx == fmatch_ff[1]); // R11

    // Next request and vector; slot 0 takes precedence if both slots match.
    // The disable bit gates only the request, so software can still read the
    // winner and its level code while interrupts are held off.
    always_comb begin
        nxt_core            = '0;
        nxt_core.req        = win_found && !int_dis_ff; // R4
        nxt_core.level_code = level_code(win_found, win_lvl); // R8
        nxt_core.fast       = fast0 | fast1; // R13 R14
        if (fast0) begin
            nxt_core.addr = {fhigh_ff[0], flow_ff[0]}; // R12
        end else if (fast1) begin
            nxt_core.addr = {fhigh_ff[1], flow_ff[1]}; // R12
        end else begin
            nxt_core.addr = {vbase_ff, 1'b0, win_idx}; // R5
        end
    end

    // ======================================================================
    // Start-up and core outputs.
    // The first cycle after reset drives the start address with no request.
    // Holding the start address one cycle past reset gives the core a full
    // cycle to fetch from it before any vector can replace it.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            state_ff <= ST_BOOT;
        end else begin
            case (state_ff)
                ST_BOOT: state_ff <= ST_RUN;
                ST_RUN:  state_ff <= ST_RUN;
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    // Vector and fast flag are registered together so the core sees them settled.
    // This costs one cycle of latency but keeps the fast choice free of glitches,
    // since address and flag always change on the same edge.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            core_ff      <= '0;
            core_ff.boot <= 1'b1; // R15
            core_ff.addr <= RESET_ADDR; // R15
        end else if (state_ff == ST_BOOT) begin
            core_ff      <= '0;
            core_ff.boot <= 1'b1; // R15
            core_ff.addr <= RESET_ADDR; // R15
        end else begin
            core_ff <= nxt_core; // R4 R13
        end
    end

    assign o_core = core_ff;

    // ======================================================================
    // Low-power wake.
    // Enables are frozen at entry, so a source enabled later cannot wake.
    // The entry edge is found by comparing the level with its delayed copy,
    // which rests low after reset so no false entry follows it.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            lp_d_ff    <= 1'b0;
            wake_en_ff <= '0;
        end else begin
            lp_d_ff <= i_low_power;
            if (i_low_power && !lp_d_ff) begin
                wake_en_ff <= src_en; // R18
            end
        end
    end

    // Wake request stands while a frozen-enabled source is pending.
    // It waits one cycle after entry so the frozen enables are in place first.
    // Leaving low power drops the request at the next edge.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= i_low_power && lp_d_ff && |(pending_ff & wake_en_ff); // R17 R18
        end
    end

    assign o_wake_req = wake_ff;

endmodule // prioritised_interrupt_controller

`default_nettype wire

/* File: test/pic_props.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Port checker for the interrupt controller.
module pic_props
    import pic_pkg::*;
#(
    parameter int          NUM_SRC    = 64,
    parameter logic [20:0] RESET_ADDR = 21'h000000
) (
    // Clock and reset.
    input wire logic               i_sys_clk,
    input wire logic               i_sys_rst,
    // Register port.
    input wire bus_req_t           i_bus,
    input wire bus_rsp_t           o_bus,
    // Sources, mask and core side.
    input wire logic [NUM_SRC-1:0] i_irq_src,
    input wire logic [1:0]         i_core_mask,
    input wire core_req_t          o_core,
    // Low-power handshake.
    input wire logic               i_low_power,
    input wire logic               o_wake_req
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    // A read or write strobe taken on this edge.
    sequence s_bus_req;
        i_bus.rd || i_bus.wr;
    endsequence

    // Sources reach the core two edges late, the mask one edge late.
    a_bus_ack: assert property (s_bus_req |=> o_bus.ack)
        else $error("bus request not acknowledged");
    a_ack_cause: assert property (o_bus.ack |-> $past(i_bus.rd || i_bus.wr))
        else $error("acknowledge without request");
    a_rdata_idle: assert property (!o_bus.ack |-> o_bus.rdata == 16'h0000)
        else $error("read data outside acknowledge");
    a_boot_addr: assert property ($past(i_sys_rst) |-> o_core.boot && o_core.addr == RESET_ADDR && !o_core.req)
        else $error("start address missing after reset");
    a_mask_level: assert property (o_core.req |-> o_core.level_code > $past(i_core_mask) || o_core.level_code == 2'b11)
        else $error("masked level presented");
    a_req_cause: assert property (o_core.req |-> $past(i_irq_src, 2) != '0)
        else $error("request without pending source");
    a_fast_level: assert property (o_core.fast |-> o_core.level_code == 2'b11 && !o_core.boot)
        else $error("fast request off the fast level");
    a_src0_wins: assert property ($past(i_irq_src[0], 2) |-> o_core.addr[5:0] == 6'h00 && !o_core.fast)
        else $error("source zero lost arbitration");
    a_wake_cause: assert property (o_wake_req |-> $past(i_low_power) && $past(i_low_power, 2))
        else $error("wake request outside low power");
    a_wake_pend: assert property (o_wake_req |-> $past(i_irq_src, 2) != '0)
        else $error("wake request without source");
endmodule // pic_props

bind prioritised_interrupt_controller pic_props #(.NUM_SRC(NUM_SRC), .RESET_ADDR(RESET_ADDR)) u_props (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_bus(o_bus), .i_irq_src(i_irq_src),
    .i_core_mask(i_core_mask), .o_core(o_core), .i_low_power(i_low_power), .o_wake_req(o_wake_req));

`default_nettype wire

/* File: test/core_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Core side: status mask bits and the fast-handling decision.
module core_model
    import pic_pkg::*;
(
    // Clock and reset.
    input  wire logic      i_sys_clk,
    input  wire logic      i_sys_rst,
    // Controller output, mask command and fetched word kind.
    input  wire core_req_t i_core,
    input  wire logic [1:0] i_mask_cmd,
    input  wire logic      i_word_is_jump,
    // Mask bits and fast handling flag.
    output logic [1:0]     o_core_mask,
    output logic           o_fast_run
);
    logic [1:0] mask_ff;
    logic       fast_ff;

    // The mask is a register, so a new level only takes hold one edge later.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            mask_ff <= 2'h0;
            fast_ff <= 1'b0;
        end else begin
            mask_ff <= i_mask_cmd;
            fast_ff <= i_core.req & i_core.fast & ~i_word_is_jump;
        end
    end

    // Outputs straight from the registers.
    assign o_core_mask = mask_ff;
    assign o_fast_run  = fast_ff;
endmodule // core_model

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Testbench for the interrupt controller.
module tb_top;
    import pic_pkg::*;
    logic        clk, rst, lp, jump, wake, frun;
    logic [1:0]  mcmd, mask;
    logic [63:0] src;
    bus_req_t    bq;
    bus_rsp_t    bs;
    core_req_t   cr;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc = 0;

    prioritised_interrupt_controller uut (.i_sys_clk(clk), .i_sys_rst(rst), .i_bus(bq), .o_bus(bs),
        .i_irq_src(src), .i_core_mask(mask), .o_core(cr), .i_low_power(lp), .o_wake_req(wake));
    core_model u_core (.i_sys_clk(clk), .i_sys_rst(rst), .i_core(cr), .i_mask_cmd(mcmd),
        .i_word_is_jump(jump), .o_core_mask(mask), .o_fast_run(frun));

    // Free-running clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // A hang counts as a failure and ends the run.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            close_out;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // One strobe per call; the answer is looked at in the cycle it stands.
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [15:0] e);
        @(negedge clk) bq = '{rd: ~w, wr: w, addr: a, wdata: d};
        @(negedge clk) bq = '0;
        check(bs.ack, 1'b1);
        if (!w) check(bs.rdata, e);
    endtask

    // Sources change off the edge; two edges of latency, one spare.
    task automatic put(input logic [63:0] v);
        @(negedge clk) src = v;
        repeat (3) @(negedge clk);
    endtask

    task automatic core_chk(input logic r, input logic [1:0] l, input logic f, input logic [20:0] a);
        check(cr.req, r);
        check(cr.level_code, l);
        check(cr.fast, f);
        check(cr.addr, a);
        check(cr.boot, 1'b0);
    endtask

    function automatic logic [20:0] nvec(input logic [5:0] i);
        return {14'h0123, 1'b0, i};
    endfunction

    // Reset values, field widths, read-only and unmapped places.
    task automatic t_regs;
        acc(0, 5'h16, 0, 16'h001c);
        acc(0, 5'h00, 0, 16'h0000);
        acc(1, 5'h07, 16'hffff, 0);
        acc(0, 5'h07, 0, 16'h3fff);
        acc(1, 5'h08, 16'hffff, 0);
        acc(0, 5'h08, 0, 16'h003f);
        acc(1, 5'h0a, 16'hffff, 0);
        acc(0, 5'h0a, 0, 16'h001f);
        acc(1, 5'h12, 16'hffff, 0);
        acc(0, 5'h12, 0, 16'h0000);
        acc(1, 5'h0e, 16'hffff, 0);
        acc(0, 5'h0e, 0, 16'h0000);
    endtask

    // Levels, lowest-number wins, masking and fixed sources.
    task automatic t_arb;
        acc(1, 5'h00, 16'h003d, 0);
        acc(1, 5'h06, 16'h8000, 0);
        acc(0, 5'h06, 0, 16'h8000);
        acc(1, 5'h07, 16'h0123, 0);
        acc(1, 5'h08, 16'h0000, 0);
        put(64'h0100);
        core_chk(1, 2'b01, 0, nvec(6'd8));
        put(64'h0300);
        core_chk(1, 2'b11, 0, nvec(6'd9));
        put(64'h0600);
        core_chk(1, 2'b11, 0, nvec(6'd9));
        put(64'h8000_0000_0000_0100);
        core_chk(1, 2'b10, 0, nvec(6'd63));
        mcmd = 2'b10;
        put(64'h8000_0000_0000_0100);
        check(cr.req, 1'b0);
        mcmd = 2'b11;
        put(64'h0229);
        core_chk(1, 2'b11, 0, nvec(6'd0));
        acc(0, 5'h16, 0, 16'he01c);
        mcmd = 2'b00;
    endtask

    // Both fast slots, and a match that is not at the fast level.
    task automatic t_fast;
        acc(1, 5'h08, 16'h0009, 0);
        acc(1, 5'h09, 16'hbeef, 0);
        acc(1, 5'h0a, 16'h0015, 0);
        acc(1, 5'h0b, 16'h000a, 0);
        acc(1, 5'h0c, 16'h1234, 0);
        acc(1, 5'h0d, 16'h000a, 0);
        acc(0, 5'h09, 0, 16'hbeef);
        acc(0, 5'h0c, 0, 16'h1234);
        acc(0, 5'h0d, 0, 16'h000a);
        put(64'h0200);
        core_chk(1, 2'b11, 1, {5'h15, 16'hbeef});
        check(frun, 1'b1);
        jump = 1'b1;
        @(negedge clk);
        check(frun, 1'b0);
        jump = 1'b0;
        put(64'h0400);
        core_chk(1, 2'b11, 1, {5'h0a, 16'h1234});
        acc(1, 5'h0b, 16'h003f, 0);
        put(64'h8000_0000_0000_0000);
        core_chk(1, 2'b10, 0, nvec(6'd63));
    endtask

    // Pending words and the disable bit.
    task automatic t_pend;
        acc(1, 5'h08, 16'h0000, 0);
        put(64'h8000_0000_0000_0200);
        acc(0, 5'h0e, 0, 16'h0200);
        acc(0, 5'h11, 0, 16'h8000);
        acc(1, 5'h16, 16'h0020, 0);
        repeat (2) @(negedge clk);
        core_chk(0, 2'b11, 0, nvec(6'd9));
        acc(0, 5'h16, 0, 16'h627c);
        acc(1, 5'h16, 16'h0000, 0);
    endtask

    // Wake only from sources enabled before low power was entered.
    task automatic t_wake;
        put(64'h0);
        lp = 1'b1;
        put(64'h0);
        check(wake, 1'b0);
        put(64'h0200);
        check(wake, 1'b1);
        put(64'h0800);
        check(wake, 1'b0);
        acc(1, 5'h00, 16'h00fd, 0);
        put(64'h0800);
        check(wake, 1'b0);
        lp = 1'b0;
        put(64'h0);
    endtask

    // Main sequence: reset for eight cycles, then each scenario in turn.
    initial begin
        bq   = '0;
        src  = '0;
        lp   = 1'b0;
        jump = 1'b0;
        mcmd = 2'b00;
        rst  = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check(cr.boot, 1'b1);
        check(cr.addr, 21'h000000);
        t_regs;
        t_arb;
        t_fast;
        t_pend;
        t_wake;
        close_out;
    end
endmodule // tb_top

`default_nettype wire
